// *** hw/ldoseq_params.svh ***
// Register offsets, field positions, reset values and timing figures of the rail A2 sequencer
`ifndef LDOSEQ_PARAMS_SVH
`define LDOSEQ_PARAMS_SVH
`define LDOSEQ_OFS_MASK_MAIN 8'h1C
`define LDOSEQ_OFS_PIN_SEL 8'h1D
`define LDOSEQ_OFS_DELAYS 8'h1E
`define LDOSEQ_RST_MASK_MAIN 8'h00
`define LDOSEQ_RST_PIN_SEL 8'h40
`define LDOSEQ_RST_DELAYS 8'h00
`define LDOSEQ_SEL_HI 4
`define LDOSEQ_SEL_LO 2
`define LDOSEQ_MASK_PAIR_BIT 1
`define LDOSEQ_MASK_SB1_BIT 0
`define LDOSEQ_RISE_HI 2
`define LDOSEQ_RISE_LO 0
`define LDOSEQ_FALL_HI 5
`define LDOSEQ_FALL_LO 3
`define LDOSEQ_OFF_HI 7
`define LDOSEQ_OFF_LO 6
`define LDOSEQ_CLK_MHZ 125
`define LDOSEQ_MS_NS 1000000
`define LDOSEQ_CLK_NS 8
`define LDOSEQ_DLY_MS_C0 7'h00
`define LDOSEQ_DLY_MS_C1 7'h02
`define LDOSEQ_DLY_MS_C2 7'h04
`define LDOSEQ_DLY_MS_C3 7'h08
`define LDOSEQ_DLY_MS_C4 7'h10
`define LDOSEQ_DLY_MS_C5 7'h18
`define LDOSEQ_DLY_MS_C6 7'h20
`define LDOSEQ_DLY_MS_C7 7'h40
`define LDOSEQ_OFF_MS_C0 7'h01
`define LDOSEQ_OFF_MS_C1 7'h05
`define LDOSEQ_OFF_MS_C2 7'h0A
`define LDOSEQ_OFF_MS_C3 7'h64
`endif

// *** hw/ldoseq_pkg.sv ***
// Types shared by the rail A2 sequencer
package ldoseq_pkg;
	typedef enum logic [2:0] {
		LDOSEQ_SRC_PIN1, LDOSEQ_SRC_PIN2, LDOSEQ_SRC_PIN5, LDOSEQ_SRC_PIN4,
		LDOSEQ_SRC_PIN3, LDOSEQ_SRC_PIN34, LDOSEQ_SRC_PIN6, LDOSEQ_SRC_ONE
	} ldoseq_src_type;
	typedef enum logic [1:0] {LDOSEQ_OFF, LDOSEQ_RISING, LDOSEQ_ON, LDOSEQ_FALLING} ldoseq_state_type;
endpackage : ldoseq_pkg

// *** hw/ldoseq_rail_a2.sv ***
// Enable sequencer for rail A2: source select, power-good gating, edge delays, rail A1 off time
// What this block does
// - Eight mask bits remove rail A3, switch A1, converters 6..1 power-good from enabling
// - Second register bits 1 and 0 mask switch B2/rail A1 pair and switch B1
// - Select field bits 4:2 picks control pin 1,2,5,4,3, pins 3 and 4, or 6
// - Select code 111 feeds constant one, rail enabled without any pin
// - Rising enable edge delayed by bits 2:0: none,2,4,8,16,24,32,64 ms
// - Falling enable edge delayed by bits 5:3 with the same table
// - Bits 7:6 set rail A1 shutdown off time: 1, 5, 10, 100 ms
`timescale 1ns/1ps
`include "ldoseq_params.svh"
module ldoseq_rail_a2 #(
	parameter int MS_CYCLES = (`LDOSEQ_MS_NS + `LDOSEQ_CLK_NS - 1) / `LDOSEQ_CLK_NS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	output logic [7:0] regRdata,
	input wire logic [6:1] controlPin,
	input wire logic [7:0] powerGoodMain,
	input wire logic powerGoodPair,
	input wire logic powerGoodSwitchB1,
	input wire logic railA1Shutdown,
	output logic railA2Enable,
	output logic railA1OffActive,
	output logic railA1OffDone
);
	import ldoseq_pkg::*;

	logic [7:0] maskMain_reg;
	logic [7:0] pinSel_reg;
	logic [7:0] delays_reg;
	logic [16:0] msCount_reg;
	logic msTick;
	logic [16:0] offCycle_reg;
	logic offTick;
	logic [6:0] delayCount_reg;
	logic [6:0] delayCount_next;
	logic [6:0] offCount_reg;
	logic [6:0] offCount_next;
	logic offActive_reg;
	logic offDone_reg;
	logic shutdownSeen_reg;
	ldoseq_state_type state_reg;
	ldoseq_state_type state_next;
	logic enable_reg;

	// Code to milliseconds; shared by rising and falling delays
	function automatic logic [6:0] ldoseq_delay_ms(input logic [2:0] code);
		unique case (code)
			3'h0: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C0;
			3'h1: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C1;
			3'h2: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C2;
			3'h3: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C3;
			3'h4: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C4;
			3'h5: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C5;
			3'h6: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C6;
			3'h7: ldoseq_delay_ms = `LDOSEQ_DLY_MS_C7;
		endcase
	endfunction : ldoseq_delay_ms

	// Register decode and readback
	wire hitMain = regAddr == `LDOSEQ_OFS_MASK_MAIN;
	wire hitSel = regAddr == `LDOSEQ_OFS_PIN_SEL;
	wire hitDly = regAddr == `LDOSEQ_OFS_DELAYS;
	assign regRdata = hitMain ? maskMain_reg : hitSel ? pinSel_reg : hitDly ? delays_reg : 8'h00;

	// Register writes; all three are plain read/write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			maskMain_reg <= `LDOSEQ_RST_MASK_MAIN;
			pinSel_reg <= `LDOSEQ_RST_PIN_SEL;
			delays_reg <= `LDOSEQ_RST_DELAYS;
		end else if (regWrite) begin
			if (hitMain) maskMain_reg <= regWdata;
			if (hitSel) pinSel_reg <= regWdata;
			if (hitDly) delays_reg <= regWdata;
		end
	end

	// Source multiplexer
	ldoseq_src_type srcSel;
	assign srcSel = ldoseq_src_type'(pinSel_reg[`LDOSEQ_SEL_HI:`LDOSEQ_SEL_LO]);
	logic srcLevel;
	always_comb begin
		unique case (srcSel)
			LDOSEQ_SRC_PIN1: srcLevel = controlPin[1];
			LDOSEQ_SRC_PIN2: srcLevel = controlPin[2];
			LDOSEQ_SRC_PIN5: srcLevel = controlPin[5];
			LDOSEQ_SRC_PIN4: srcLevel = controlPin[4];
			LDOSEQ_SRC_PIN3: srcLevel = controlPin[3];
			LDOSEQ_SRC_PIN34: srcLevel = controlPin[3] & controlPin[4];
			LDOSEQ_SRC_PIN6: srcLevel = controlPin[6];
			LDOSEQ_SRC_ONE: srcLevel = 1'b1;
		endcase
	end

	// Masked power-good gate; a mask bit of one forces that flag true
	wire pgMainOk = &(powerGoodMain | maskMain_reg);
	wire pgPairOk = powerGoodPair | pinSel_reg[`LDOSEQ_MASK_PAIR_BIT];
	wire pgSb1Ok = powerGoodSwitchB1 | pinSel_reg[`LDOSEQ_MASK_SB1_BIT];
	wire request = srcLevel & pgMainOk & pgPairOk & pgSb1Ok;

	// Millisecond time base, held at zero while idle so each delay is whole milliseconds
	// Limitation: MS_CYCLES must fit the 17-bit prescalers
	wire edgeIdle = (state_reg == LDOSEQ_OFF) || (state_reg == LDOSEQ_ON);
	assign msTick = msCount_reg == 17'(MS_CYCLES - 1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) msCount_reg <= 17'h00000;
		else msCount_reg <= (edgeIdle || msTick) ? 17'h00000 : msCount_reg + 17'h00001;
	end

	wire [6:0] riseMs = ldoseq_delay_ms(delays_reg[`LDOSEQ_RISE_HI:`LDOSEQ_RISE_LO]);
	wire [6:0] fallMs = ldoseq_delay_ms(delays_reg[`LDOSEQ_FALL_HI:`LDOSEQ_FALL_LO]);

	// Edge delay machine; a request that reverts mid-delay cancels the pending edge
	always_comb begin
		state_next = state_reg;
		delayCount_next = delayCount_reg;
		unique case (state_reg)
			LDOSEQ_OFF: if (request) begin
				if (riseMs == 7'h00) state_next = LDOSEQ_ON;
				else begin
					state_next = LDOSEQ_RISING;
					delayCount_next = riseMs;
				end
			end
			LDOSEQ_RISING: if (!request) state_next = LDOSEQ_OFF;
				else if (msTick) begin
					if (delayCount_reg == 7'h01) state_next = LDOSEQ_ON;
					delayCount_next = delayCount_reg - 7'h01;
				end
			LDOSEQ_ON: if (!request) begin
				if (fallMs == 7'h00) state_next = LDOSEQ_OFF;
				else begin
					state_next = LDOSEQ_FALLING;
					delayCount_next = fallMs;
				end
			end
			LDOSEQ_FALLING: if (request) state_next = LDOSEQ_ON;
				else if (msTick) begin
					if (delayCount_reg == 7'h01) state_next = LDOSEQ_OFF;
					delayCount_next = delayCount_reg - 7'h01;
				end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= LDOSEQ_OFF;
			delayCount_reg <= 7'h00;
			enable_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			delayCount_reg <= delayCount_next;
			enable_reg <= (state_next == LDOSEQ_ON) || (state_next == LDOSEQ_FALLING);
		end
	end
	assign railA2Enable = enable_reg;

	// Rail A1 off time: started by the rising edge of the shutdown level
	wire [6:0] offMs = (delays_reg[`LDOSEQ_OFF_HI:`LDOSEQ_OFF_LO] == 2'h0) ? `LDOSEQ_OFF_MS_C0 :
		(delays_reg[`LDOSEQ_OFF_HI:`LDOSEQ_OFF_LO] == 2'h1) ? `LDOSEQ_OFF_MS_C1 :
		(delays_reg[`LDOSEQ_OFF_HI:`LDOSEQ_OFF_LO] == 2'h2) ? `LDOSEQ_OFF_MS_C2 :
		`LDOSEQ_OFF_MS_C3;
	wire offStart = railA1Shutdown & ~shutdownSeen_reg;
	assign offCount_next = offStart ? offMs : (offActive_reg && offTick) ?
		offCount_reg - 7'h01 : offCount_reg;

	// Own prescaler, restarted at each start, so a 1 ms off time is never cut short
	assign offTick = offCycle_reg == 17'(MS_CYCLES - 1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) offCycle_reg <= 17'h00000;
		else offCycle_reg <= (offStart || !offActive_reg || offTick) ? 17'h00000 :
			offCycle_reg + 17'h00001;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shutdownSeen_reg <= 1'b0;
			offCount_reg <= 7'h00;
			offActive_reg <= 1'b0;
			offDone_reg <= 1'b0;
		end else begin
			shutdownSeen_reg <= railA1Shutdown;
			offCount_reg <= offCount_next;
			offActive_reg <= offStart | (offActive_reg & (offCount_next != 7'h00));
			offDone_reg <= railA1Shutdown & ~offStart & (offDone_reg | (offActive_reg &
				(offCount_next == 7'h00)));
		end
	end
	assign railA1OffActive = offActive_reg;
	assign railA1OffDone = offDone_reg;

	// Checks on the sequencing behaviour
	AST_CONST_ONE: assert property (@(posedge clk) disable iff (!resetn)
		(srcSel == LDOSEQ_SRC_ONE && pgMainOk && pgPairOk && pgSb1Ok) |-> request)
		else $error("constant-one source did not request");
	AST_MASK_MAIN: assert property (@(posedge clk) disable iff (!resetn)
		(maskMain_reg == 8'hFF && pgPairOk && pgSb1Ok && srcLevel) |-> request)
		else $error("fully masked flags still block enable");
	AST_PAIR_GATE: assert property (@(posedge clk) disable iff (!resetn)
		(!pinSel_reg[`LDOSEQ_MASK_PAIR_BIT] && !powerGoodPair) |-> !request)
		else $error("unmasked pair flag ignored");
	AST_PIN34: assert property (@(posedge clk) disable iff (!resetn)
		(srcSel == LDOSEQ_SRC_PIN34 && !(controlPin[3] && controlPin[4])) |-> !request)
		else $error("pin pair source not anded");
	AST_NO_EARLY: assert property (@(posedge clk) disable iff (!resetn)
		(!request && state_reg == LDOSEQ_OFF) |=> !railA2Enable)
		else $error("enable rose without request");
	AST_RISE_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == LDOSEQ_OFF && request && riseMs == 7'h00) |=> railA2Enable)
		else $error("zero rise delay not immediate");
	AST_RISE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == LDOSEQ_OFF && request && riseMs != 7'h00) |=> !railA2Enable)
		else $error("rise delay skipped");
	AST_FALL_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == LDOSEQ_ON && !request && fallMs != 7'h00) |=> railA2Enable)
		else $error("fall delay skipped");
	AST_OFF_START: assert property (@(posedge clk) disable iff (!resetn)
		offStart |=> (railA1OffActive && offCount_reg == $past(offMs)))
		else $error("off time not loaded");
	AST_RISE_LOAD: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == LDOSEQ_OFF && request && riseMs != 7'h00)
		|=> (delayCount_reg == $past(riseMs)))
		else $error("rise delay not loaded");
	AST_FALL_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == LDOSEQ_ON && !request && fallMs == 7'h00) |=> !railA2Enable)
		else $error("zero fall delay not immediate");
	AST_OFF_DONE: assert property (@(posedge clk) disable iff (!resetn)
		(offActive_reg && offTick && offCount_reg == 7'h01 && railA1Shutdown && !offStart)
		|=> (railA1OffDone && !railA1OffActive))
		else $error("off time did not complete");
endmodule : ldoseq_rail_a2

// *** tb/ldoseq_host_model.sv ***
// Host-side model driving the control pins and power-good levels
`timescale 1ns/1ps
module ldoseq_host_model (
	input wire logic clk,
	input wire logic [6:1] pinLevel,
	input wire logic [9:0] goodLevel,
	output logic [6:1] controlPin,
	output logic [7:0] powerGoodMain,
	output logic powerGoodPair,
	output logic powerGoodSwitchB1
);
	// Levels move on the falling edge only, clear of the sampling edge
	always @(negedge clk) begin
		controlPin <= pinLevel;
		{powerGoodSwitchB1, powerGoodPair, powerGoodMain} <= goodLevel;
	end
endmodule : ldoseq_host_model

// *** tb/testbench.sv ***
// Self-checking bench for the rail A2 sequencer
`timescale 1ns/1ps
`include "ldoseq_params.svh"
module testbench;
	logic clk = 0, resetn = 0, regWrite = 0, railA1Shutdown = 0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, powerGoodMain;
	logic [6:1] pinLevel = 6'h00, controlPin;
	logic [9:0] goodLevel = 10'h3FF;
	logic powerGoodPair, powerGoodSwitchB1, railA2Enable, railA1OffActive, railA1OffDone;
	int nFail = 0, nTests = 0, cnt;
	// Pins each select code needs, code 7 needs none
	logic [6:1] need [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
	// Delay and off-time tables in milliseconds, per code
	logic [6:0] msTab [8] = '{7'h00, 7'h02, 7'h04, 7'h08, 7'h10, 7'h18, 7'h20, 7'h40};
	logic [6:0] offTab [4] = '{7'h01, 7'h05, 7'h0A, 7'h64};
	localparam int MS_T = 10;
	always #4 clk = ~clk;
	// Short millisecond tick keeps the delay scenarios brief
	ldoseq_rail_a2 #(.MS_CYCLES(MS_T)) dut_u (.clk(clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRdata(regRdata), .controlPin(controlPin),
		.powerGoodMain(powerGoodMain), .powerGoodPair(powerGoodPair),
		.powerGoodSwitchB1(powerGoodSwitchB1), .railA1Shutdown(railA1Shutdown),
		.railA2Enable(railA2Enable), .railA1OffActive(railA1OffActive),
		.railA1OffDone(railA1OffDone));
	ldoseq_host_model host_u (.clk(clk), .pinLevel(pinLevel), .goodLevel(goodLevel),
		.controlPin(controlPin), .powerGoodMain(powerGoodMain), .powerGoodPair(powerGoodPair),
		.powerGoodSwitchB1(powerGoodSwitchB1));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWdata = d;
		regWrite = 1;
		@(negedge clk);
		regWrite = 0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(negedge clk);
		regAddr = a;
		#1;
	endtask : rd
	task edges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : edges
	task setin(input logic [6:1] p, input logic [9:0] g);
		edges(0);
		pinLevel = p;
		goodLevel = g;
		@(negedge clk);
		#1;
	endtask : setin
	// Counts edges until the enable reaches the wanted level
	task waitEn(input logic lvl);
		cnt = 0;
		while (railA2Enable !== lvl && cnt < 1000) begin
			edges(1);
			cnt++;
		end
	endtask : waitEn
	task t_regs;
		rd(`LDOSEQ_OFS_MASK_MAIN);
		chk(regRdata, 8'h00);
		rd(`LDOSEQ_OFS_PIN_SEL);
		chk(regRdata, 8'h40);
		rd(`LDOSEQ_OFS_DELAYS);
		chk(regRdata, 8'h00);
		wr(8'h1F, 8'hFF);
		rd(8'h1F);
		chk(regRdata, 8'h00);
		wr(`LDOSEQ_OFS_MASK_MAIN, 8'hA5);
		rd(`LDOSEQ_OFS_MASK_MAIN);
		chk(regRdata, 8'hA5);
		$display("test regs done");
	endtask : t_regs
	task t_source;
		wr(`LDOSEQ_OFS_MASK_MAIN, 8'hFF);
		for (int c = 0; c < 8; c++) begin
			wr(`LDOSEQ_OFS_PIN_SEL, {3'b000, c[2:0], 2'b11});
			setin(~need[c], 10'h3FF);
			edges(2);
			chk({7'h0, railA2Enable}, {7'h0, c == 7});
			setin(need[c], 10'h3FF);
			edges(1);
			chk({7'h0, railA2Enable}, 8'h01);
		end
		$display("test source done");
	endtask : t_source
	task t_mask;
		logic [9:0] m;
		for (int i = 0; i < 10; i++) begin
			m = 10'h001 << i;
			setin(6'h00, ~m);
			wr(`LDOSEQ_OFS_MASK_MAIN, 8'h00);
			wr(`LDOSEQ_OFS_PIN_SEL, 8'h1C);
			edges(2);
			chk({7'h0, railA2Enable}, 8'h00);
			wr(`LDOSEQ_OFS_MASK_MAIN, m[7:0]);
			wr(`LDOSEQ_OFS_PIN_SEL, {6'b000111, m[8], m[9]});
			edges(2);
			chk({7'h0, railA2Enable}, 8'h01);
		end
		$display("test mask done");
	endtask : t_mask
	task t_delay;
		wr(`LDOSEQ_OFS_MASK_MAIN, 8'hFF);
		wr(`LDOSEQ_OFS_PIN_SEL, 8'h03);
		wr(`LDOSEQ_OFS_DELAYS, 8'h11);
		setin(6'h00, 10'h3FF);
		edges(3);
		setin(6'h01, 10'h3FF);
		edges(5);
		setin(6'h00, 10'h3FF);
		edges(30);
		chk({7'h0, railA2Enable}, 8'h00);
		// Every code on both edges; the delay starts at the first edge that sees the request
		for (int c = 0; c < 8; c++) begin
			wr(`LDOSEQ_OFS_DELAYS, {2'b00, 3'(7 - c), 3'(c)});
			setin(6'h01, 10'h3FF);
			waitEn(1'b1);
			chk({7'h0, cnt == 1 + msTab[c] * MS_T}, 8'h01);
			setin(6'h00, 10'h3FF);
			waitEn(1'b0);
			chk({7'h0, cnt == 1 + msTab[7 - c] * MS_T}, 8'h01);
		end
		// A request that returns inside the fall delay keeps the rail on
		wr(`LDOSEQ_OFS_DELAYS, 8'h11);
		setin(6'h01, 10'h3FF);
		waitEn(1'b1);
		setin(6'h00, 10'h3FF);
		edges(5);
		setin(6'h01, 10'h3FF);
		edges(50);
		chk({7'h0, railA2Enable}, 8'h01);
		setin(6'h00, 10'h3FF);
		waitEn(1'b0);
		chk({7'h0, railA2Enable}, 8'h00);
		$display("test delay done");
	endtask : t_delay
	task t_off;
		for (int c = 0; c < 4; c++) begin
			wr(`LDOSEQ_OFS_DELAYS, {c[1:0], 6'h00});
			railA1Shutdown = 1;
			edges(1);
			chk({7'h0, railA1OffActive}, 8'h01);
			cnt = 0;
			while (railA1OffDone !== 1'b1 && cnt < 2000) begin
				edges(1);
				cnt++;
			end
			chk({5'h0, cnt == offTab[c] * MS_T, railA1OffActive, railA1OffDone}, 8'h05);
			@(negedge clk);
			railA1Shutdown = 0;
			edges(2);
			chk({7'h0, railA1OffDone}, 8'h00);
		end
		$display("test off time done");
	endtask : t_off
	// Reset in mid-run drops the enable and restores the register defaults
	task t_reset;
		wr(`LDOSEQ_OFS_PIN_SEL, 8'h1F);
		edges(2);
		chk({7'h0, railA2Enable}, 8'h01);
		@(negedge clk);
		resetn = 0;
		#1;
		chk({6'h0, railA2Enable, railA1OffActive}, 8'h00);
		rd(`LDOSEQ_OFS_PIN_SEL);
		chk(regRdata, 8'h40);
		@(negedge clk);
		resetn = 1;
		edges(2);
		chk({7'h0, railA2Enable}, 8'h00);
		rd(`LDOSEQ_OFS_MASK_MAIN);
		chk(regRdata, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task wrap_up;
		$display("checks %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// Main sequence; release reset after four cycles, off the sampling edge
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		resetn = 1;
		t_regs;
		t_source;
		t_mask;
		t_delay;
		t_off;
		t_reset;
		wrap_up;
	end
	// Watchdog about ten times the five thousand cycles the tests need
	initial begin
		#400000;
		nFail++;
		wrap_up;
	end
endmodule : testbench
